// ### core/i2c_bus_controller.v
// Two-wire bus controller: registers, master/slave byte engine, bus line handling
// How it works
// - Address bit 0 exists only in 10-bit mode; reads zero in 7-bit mode.
// - 7-bit mode address in bits 7:1; bit 8 becomes ignore-end control.
// - Ignore-end zero halts on end request; effective only in 7-bit mode.
// - 10-bit mode keeps all ten low bits, bit 0 only then; matching uses bits 7:1 in both modes.
// - Pre-divider field 14:13 bypasses, divides by 8 or 64.
// - Bit 15 picks reciprocal (reset) or fractional baud mode.
// - Reciprocal bit rate is clock over four times prescaler plus one.
// - Fractional bit rate is clock times prescaler over 1024.
// - Prescaler is ten bits: eight low in pin-enable upper byte.
// - Four buffer bytes, length selects one to four, byte zero first.
// - Software access to all enabled bytes sets tally to 111.
// - With auto-clear select zero, that access clears data request.
// - Data request rises after acknowledge of last buffered byte.
// - Early slave-write end raises data request, then end request.
// - Protocol request on lost arbitration or slave selection.
// - End request on stop, repeated start or missing acknowledge.
// - Clock low period timed per node; wired-AND stretching respected.
// - Busy-master set sends start; acknowledge lands in last-received bit.
// - Clearing busy-master stops now; stop-master stops after transfer.
// - Any request flag set while engaged holds the clock line low.
// - Operating setting 00 init and abort, 01 slave, 10 master, 11 multi.
`timescale 1ns/100ps
`include "i2c_ctrl_map.vh"
module i2c_bus_controller (
  input wire REF_CLK,
  input wire RST_B,
  input wire [2:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  input wire SCL_IN,
  output reg SCL_OUT,
  output reg SCL_OE,
  output reg DATA_SERVICE_LINE,
  output reg PROTOCOL_SERVICE_LINE,
  output reg END_SERVICE_LINE
);
  ////////////////////////////////////////////////////////////////////////////
  // Engine states
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_BIT = 3'h2;
  localparam ST_ACK = 3'h3;
  localparam ST_HOLD = 3'h4;
  localparam ST_STOP = 3'h5;
  localparam ST_SLAVE = 3'h6;
  // Register state
  reg [15:0] pin_enable_reg;
  reg [15:0] control_reg;
  reg [15:0] node_address_reg;
  reg [7:0] buffer_reg [0:3];
  reg [2:0] tally_reg;
  reg [3:0] touched_reg;
  reg data_transfer_request;
  reg protocol_event_request;
  reg transmission_end_request;
  reg arbitration_lost_reg;
  reg slave_selected_reg;
  reg last_received_bit;
  reg bus_busy_reg;
  // Line synchronisers
  reg sda_meta_reg, sda_sync_reg, sda_prev_reg;
  reg scl_meta_reg, scl_sync_reg, scl_prev_reg;
  // Engine
  reg [2:0] state_reg;
  reg [1:0] phase_reg;
  reg [2:0] bit_reg;
  reg [1:0] byte_reg;
  reg [7:0] shift_reg;
  reg stop_pending_reg;
  reg restart_active_reg;
  reg [1:0] rel_age_reg;
  wire stretched;
  wire quarter_tick;
  wire [1:0] operating_setting;
  wire ten_bit_addressing;
  wire [9:0] baud_prescaler_value;
  wire [1:0] last_slot;
  wire any_request;
  wire start_seen;
  wire stop_seen;
  wire scl_rise;
  wire engaged;
  wire transmit_select;
  wire buf_access;
  wire all_touched;
  wire [15:0] status_word;
  wire [15:0] address_view;
  integer i;
  assign operating_setting = control_reg[`CTL_MODE_HI:`CTL_MODE_LO];
  assign ten_bit_addressing = control_reg[`CTL_TEN_BIT];
  assign transmit_select = control_reg[`CTL_TRANSMIT];
  assign last_slot = control_reg[`CTL_LEN_HI:`CTL_LEN_LO];
  assign baud_prescaler_value = {node_address_reg[9:8], pin_enable_reg[15:8]};
  assign any_request = data_transfer_request | protocol_event_request | transmission_end_request;
  // START is SDA falling while SCL high, STOP the rise
  assign start_seen = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign stop_seen = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
  assign scl_rise = scl_sync_reg & ~scl_prev_reg;
  // Only a line still low after our own release has passed the synchroniser counts as stretching
  assign stretched = !scl_sync_reg && rel_age_reg == 2'h3;
  assign engaged = (state_reg != ST_IDLE) || slave_selected_reg;
  assign buf_access = (WR && transmit_select || RD && !transmit_select) &&
                      (ADDR == `OFS_BUFFER_LOWER || ADDR == `OFS_BUFFER_UPPER);
  // Both buffer words touch two slots; enabled slots all seen ends the round
  assign all_touched = (touched_reg | slot_mask(ADDR, buf_access)) >= len_mask(last_slot) &&
                       ((touched_reg | slot_mask(ADDR, buf_access)) & len_mask(last_slot)) == len_mask(last_slot);
  assign status_word = {5'h00, tally_reg, transmission_end_request, protocol_event_request,
                        data_transfer_request, bus_busy_reg, last_received_bit, slave_selected_reg,
                        arbitration_lost_reg, 1'b0};
  // Low address bit and bit 8 differ by addressing mode
  assign address_view = ten_bit_addressing ? node_address_reg : {node_address_reg[15:1], 1'b0};

  // Slot mask touched by one buffer access
  function [3:0] slot_mask;
    input [2:0] a;
    input hit;
    begin
      slot_mask = !hit ? 4'h0 : (a == `OFS_BUFFER_LOWER) ? 4'h3 : 4'hc;
    end
  endfunction

  // Slots enabled by the length field
  function [3:0] len_mask;
    input [1:0] n;
    begin
      case (n)
        2'h0: len_mask = 4'h1;
        2'h1: len_mask = 4'h3;
        2'h2: len_mask = 4'h7;
        default: len_mask = 4'hf;
      endcase
    end
  endfunction

  i2c_baud_gen baud (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .fractional(node_address_reg[`ADR_FRACTIONAL]),
    .pre_div(node_address_reg[`ADR_BAUD_PRE_DIVIDER_HI:`ADR_BAUD_PRE_DIVIDER_LO]),
    .prescaler(baud_prescaler_value),
    .quarter_tick(quarter_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; the second stage and a previous-value copy of it for edge detection are looked at
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
    end else begin
      sda_meta_reg <= SDA_IN;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      scl_meta_reg <= SCL_IN;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
    end
  end

  // Cycles since we let go of the clock; without it short quarters would stall on sync latency
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B)
      rel_age_reg <= 2'h0;
    else if (SCL_OE)
      rel_age_reg <= 2'h0;
    else if (rel_age_reg != 2'h3)
      rel_age_reg <= rel_age_reg + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file, flags and byte engine share one process so flags have one driver.
  // Hardware set beats a software clear in the same cycle.
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_enable_reg <= `RESET_WORD;
      control_reg <= `RESET_WORD;
      node_address_reg <= `RESET_WORD;
      for (i = 0; i < 4; i = i + 1)
        buffer_reg[i] <= 8'h00;
      tally_reg <= `TALLY_NONE;
      touched_reg <= 4'h0;
      data_transfer_request <= 1'b0;
      protocol_event_request <= 1'b0;
      transmission_end_request <= 1'b0;
      arbitration_lost_reg <= 1'b0;
      slave_selected_reg <= 1'b0;
      last_received_bit <= 1'b0;
      bus_busy_reg <= 1'b0;
      state_reg <= ST_IDLE;
      phase_reg <= 2'h0;
      bit_reg <= 3'h0;
      byte_reg <= 2'h0;
      shift_reg <= 8'h00;
      stop_pending_reg <= 1'b0;
      restart_active_reg <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      SCL_OUT <= 1'b0;
      SCL_OE <= 1'b0;
    end else begin
      // Software writes
      if (WR) begin
        case (ADDR)
          `OFS_PIN_ENABLE: pin_enable_reg <= WDATA;
          `OFS_CONTROL: begin
            control_reg <= WDATA;
            if (!WDATA[`CTL_BUSY_MASTER] && control_reg[`CTL_BUSY_MASTER] && state_reg != ST_IDLE)
              state_reg <= ST_STOP;
            if (WDATA[`CTL_STOP])
              stop_pending_reg <= 1'b1;
          end
          `OFS_STATUS: begin
            data_transfer_request <= WDATA[5];
            protocol_event_request <= WDATA[6];
            transmission_end_request <= WDATA[7];
            arbitration_lost_reg <= WDATA[1];
          end
          `OFS_NODE_ADDRESS: begin
            if (ten_bit_addressing)
              node_address_reg <= WDATA;
            else
              node_address_reg <= {WDATA[15:9], WDATA[8], WDATA[7:1], node_address_reg[0]};
          end
          `OFS_BUFFER_LOWER: begin
            buffer_reg[0] <= WDATA[7:0];
            buffer_reg[1] <= WDATA[15:8];
          end
          `OFS_BUFFER_UPPER: begin
            buffer_reg[2] <= WDATA[7:0];
            buffer_reg[3] <= WDATA[15:8];
          end
          default: ;
        endcase
      end
      // Buffer round bookkeeping
      if (buf_access) begin
        last_received_bit <= 1'b0;
        if (all_touched) begin
          touched_reg <= 4'h0;
          tally_reg <= `TALLY_NONE;
          if (!control_reg[`CTL_INT_SELECT])
            data_transfer_request <= 1'b0;
        end else begin
          touched_reg <= touched_reg | slot_mask(ADDR, buf_access);
        end
      end
      // Bus busy tracking from line conditions
      if (start_seen)
        bus_busy_reg <= 1'b1;
      if (stop_seen || operating_setting == `MODE_INIT)
        bus_busy_reg <= 1'b0;
      // Hold clock low while a request is pending and we are engaged
      if (any_request && engaged) begin
        SCL_OE <= 1'b1;
      end
      // Init mode aborts the engine, releases both lines and drops slave selection
      if (operating_setting == `MODE_INIT) begin
        state_reg <= ST_IDLE;
        SDA_OE <= 1'b0;
        SCL_OE <= 1'b0;
        slave_selected_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            SDA_OE <= 1'b0;
            if (!any_request)
              SCL_OE <= 1'b0;
            if (control_reg[`CTL_BUSY_MASTER] && operating_setting[1]) begin
              if (bus_busy_reg) begin
                arbitration_lost_reg <= 1'b1;
                protocol_event_request <= 1'b1;
                control_reg[`CTL_BUSY_MASTER] <= 1'b0;
              end else begin
                state_reg <= ST_START;
                phase_reg <= 2'h0;
              end
            end else if (start_seen && operating_setting != `MODE_MASTER) begin
              state_reg <= ST_SLAVE;
              bit_reg <= 3'h7;
            end
          end
          ST_START: if (quarter_tick) begin
            // Pull data low with clock high, then clock low
            phase_reg <= phase_reg + 2'h1;
            SDA_OE <= 1'b1;
            if (phase_reg == 2'h3) begin
              SCL_OE <= 1'b1;
              transmission_end_request <= 1'b0;
              state_reg <= ST_BIT;
              bit_reg <= 3'h7;
              byte_reg <= 2'h0;
              shift_reg <= buffer_reg[0];
              phase_reg <= 2'h0;
              control_reg[`CTL_RESTART] <= 1'b0;
            end
          end
          ST_BIT, ST_ACK: if (quarter_tick) begin
            // Quarter 0 sets data, 1 releases clock, 2 waits for stretching, 3 pulls low
            case (phase_reg)
              2'h0: SDA_OE <= (state_reg == ST_BIT) ? (transmit_select & ~shift_reg[7])
                                                      : ~transmit_select;
              2'h1: SCL_OE <= 1'b0;
              2'h2: if (stretched) phase_reg <= 2'h2;
              default: SCL_OE <= 1'b1;
            endcase
            if (!(phase_reg == 2'h2 && stretched))
              phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h2 && !stretched) begin
              if (state_reg == ST_BIT) begin
                if (transmit_select && shift_reg[7] && !sda_sync_reg) begin
                  arbitration_lost_reg <= 1'b1;
                  protocol_event_request <= 1'b1;
                  control_reg[`CTL_BUSY_MASTER] <= 1'b0;
                  state_reg <= ST_IDLE;
                end
                shift_reg <= {shift_reg[6:0], sda_sync_reg};
              end else begin
                last_received_bit <= sda_sync_reg;
              end
            end
            if (phase_reg == 2'h3) begin
              if (state_reg == ST_BIT) begin
                bit_reg <= bit_reg - 3'h1;
                if (bit_reg == 3'h0)
                  state_reg <= ST_ACK;
              end else begin
                if (!transmit_select)
                  buffer_reg[byte_reg] <= shift_reg;
                tally_reg <= {1'b0, byte_reg} + 3'h1;
                if (last_received_bit && transmit_select) begin
                  data_transfer_request <= 1'b1;
                  state_reg <= ST_STOP;
                end else if (byte_reg == last_slot) begin
                  data_transfer_request <= 1'b1;
                  state_reg <= ST_HOLD;
                end else begin
                  byte_reg <= byte_reg + 2'h1;
                  shift_reg <= buffer_reg[byte_reg + 2'h1];
                  bit_reg <= 3'h7;
                  state_reg <= ST_BIT;
                end
              end
            end
          end
          ST_HOLD: if (!any_request) begin
            // Clock stays low until software has serviced the request
            if (stop_pending_reg)
              state_reg <= ST_STOP;
            else if (control_reg[`CTL_RESTART]) begin
              state_reg <= ST_START;
              SCL_OE <= 1'b0;
              SDA_OE <= 1'b0;
              restart_active_reg <= 1'b1;
            end else begin
              byte_reg <= 2'h0;
              shift_reg <= buffer_reg[0];
              bit_reg <= 3'h7;
              state_reg <= ST_BIT;
            end
          end
          ST_STOP: if (quarter_tick) begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h0)
              SDA_OE <= 1'b1;
            if (phase_reg == 2'h1)
              SCL_OE <= 1'b0;
            if (phase_reg == 2'h3) begin
              SDA_OE <= 1'b0;
              stop_pending_reg <= 1'b0;
              control_reg[`CTL_BUSY_MASTER] <= 1'b0;
              control_reg[`CTL_STOP] <= 1'b0;
              if (!node_address_reg[`ADR_IGNORE_END] || ten_bit_addressing)
                transmission_end_request <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
          ST_SLAVE: begin
            // Collect the address byte on rising clock edges
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_sync_reg};
              bit_reg <= bit_reg - 3'h1;
              if (bit_reg == 3'h0) begin
                buffer_reg[0] <= {shift_reg[6:0], sda_sync_reg};
                if (shift_reg[6:0] == address_view[7:1]) begin
                  slave_selected_reg <= 1'b1;
                  protocol_event_request <= 1'b1;
                end
                state_reg <= ST_IDLE;
              end
            end
            if (stop_seen || start_seen && bit_reg != 3'h7)
              state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_IDLE;
        endcase
        if (slave_selected_reg && (stop_seen || start_seen)) begin
          slave_selected_reg <= 1'b0;
          if (!node_address_reg[`ADR_IGNORE_END] || ten_bit_addressing)
            transmission_end_request <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data one cycle after the strobe, service lines mirror the flags
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 16'h0000;
      DATA_SERVICE_LINE <= 1'b0;
      PROTOCOL_SERVICE_LINE <= 1'b0;
      END_SERVICE_LINE <= 1'b0;
    end else begin
      DATA_SERVICE_LINE <= data_transfer_request;
      PROTOCOL_SERVICE_LINE <= protocol_event_request;
      END_SERVICE_LINE <= transmission_end_request;
      RDATA <= 16'h0000;
      if (RD) begin
        case (ADDR)
          `OFS_PIN_ENABLE: RDATA <= pin_enable_reg;
          `OFS_CONTROL: RDATA <= control_reg;
          `OFS_STATUS: RDATA <= status_word;
          `OFS_NODE_ADDRESS: RDATA <= address_view;
          `OFS_BUFFER_LOWER: RDATA <= {buffer_reg[1], buffer_reg[0]};
          `OFS_BUFFER_UPPER: RDATA <= {buffer_reg[3], buffer_reg[2]};
          default: RDATA <= 16'h0000;
        endcase
      end
    end
  end
endmodule // i2c_bus_controller

// ### shared/i2c_ctrl_map.vh
// Register map, field positions, reset values and timing constants of the two-wire bus controller
`ifndef I2C_CTRL_MAP_VH
`define I2C_CTRL_MAP_VH
`define OFS_PIN_ENABLE 3'h0
`define OFS_CONTROL 3'h1
`define OFS_STATUS 3'h2
`define OFS_NODE_ADDRESS 3'h3
`define OFS_BUFFER_LOWER 3'h4
`define OFS_BUFFER_UPPER 3'h5
`define CTL_TEN_BIT 0
`define CTL_RESTART 1
`define CTL_MODE_LO 2
`define CTL_MODE_HI 3
`define CTL_BUSY_MASTER 4
`define CTL_INT_SELECT 6
`define CTL_TRANSMIT 7
`define CTL_STOP 9
`define CTL_LEN_LO 10
`define CTL_LEN_HI 11
`define ADR_IGNORE_END 8
`define ADR_BAUD_PRE_DIVIDER_LO 13
`define ADR_BAUD_PRE_DIVIDER_HI 14
`define ADR_FRACTIONAL 15
`define MODE_INIT 2'h0
`define MODE_SLAVE 2'h1
`define MODE_MASTER 2'h2
`define MODE_MULTI 2'h3
`define TALLY_NONE 3'h7
`define BAUD_PRE_DIVIDER_8 7'h07
`define BAUD_PRE_DIVIDER_64 7'h3f
`define FRAC_MODULUS 11'h400
`define RESET_WORD 16'h0000
`endif

// ### core/i2c_baud_gen.v
// Baud tick generator: pre-divider, reciprocal and fractional dividers
`timescale 1ns/100ps
`include "i2c_ctrl_map.vh"
module i2c_baud_gen (
  input wire clk,
  input wire rst_b,
  input wire fractional,
  input wire [1:0] pre_div,
  input wire [9:0] prescaler,
  output reg quarter_tick
);
  reg [6:0] pre_cnt_reg;
  reg [9:0] rec_cnt_reg;
  reg [10:0] acc_reg;
  wire pre_tick;
  wire [10:0] acc_sum;
  // Pre-divider bypass, /8, /64; code 11 behaves as bypass
  assign pre_tick = (pre_div == 2'b01) ? (pre_cnt_reg == `BAUD_PRE_DIVIDER_8) :
                    (pre_div == 2'b10) ? (pre_cnt_reg == `BAUD_PRE_DIVIDER_64) : 1'b1;
  assign acc_sum = acc_reg + {1'b0, prescaler};
  // Quarter-bit ticks; four make one bus bit
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_reg <= 7'h00;
      rec_cnt_reg <= 10'h000;
      acc_reg <= 11'h000;
      quarter_tick <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_tick ? 7'h00 : pre_cnt_reg + 7'h01;
      quarter_tick <= 1'b0;
      if (pre_tick) begin
        if (!fractional) begin
          // Reciprocal: bit rate = f / (4*(value+1))
          if (rec_cnt_reg >= prescaler) begin
            rec_cnt_reg <= 10'h000;
            quarter_tick <= 1'b1;
          end else begin
            rec_cnt_reg <= rec_cnt_reg + 10'h001;
          end
        end else begin
          // Fractional: accumulate modulo 256 (1024/4), four overflows per bit
          if (acc_sum >= (`FRAC_MODULUS >> 2)) begin
            acc_reg <= acc_sum - (`FRAC_MODULUS >> 2);
            quarter_tick <= 1'b1;
          end else begin
            acc_reg <= acc_sum;
          end
        end
      end
    end
  end
endmodule // i2c_baud_gen

// ### dv/i2c_far_node.sv
// Far-side slave node on the two-wire bus: acknowledges one byte and records what it saw
`timescale 1ns/100ps
module i2c_far_node (
  input wire clk,
  input wire rst_b,
  input wire scl,
  input wire sda,
  output reg pull,
  output reg [7:0] got,
  output reg [15:0] period
);
  reg sp;
  reg cp;
  reg [3:0] n;
  reg [15:0] cyc;
  reg [15:0] t0;
  ////////////////////////////////////////
  // Lines are sampled on the system clock; this node never stretches the clock low phase
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sp <= 1'b1;
      cp <= 1'b1;
      n <= 4'h0;
      cyc <= 16'h0000;
      t0 <= 16'h0000;
      pull <= 1'b0;
      got <= 8'h00;
      period <= 16'h0000;
    end else begin
      sp <= sda;
      cp <= scl;
      cyc <= cyc + 16'h0001;
      if (scl && cp && sp && !sda) begin
        n <= 4'h0; // Start seen: new frame
        pull <= 1'b0;
      end else if (scl && !cp) begin
        if (n < 4'h8) got <= {got[6:0], sda}; // First bit is the top bit
        if (n == 4'h0) t0 <= cyc;
        if (n == 4'h1) period <= cyc - t0;
        if (n != 4'hf) n <= n + 4'h1;
      end else if (!scl && cp) begin
        pull <= (n == 4'h8); // Acknowledge only during the ninth bit, so the line rises after it
      end
    end
  end
endmodule // i2c_far_node

// ### dv/i2c_bus_controller_sva.sv
// Port-level checker for the two-wire bus controller
`timescale 1ns/100ps
module i2c_bus_controller_sva (
  input wire REF_CLK,
  input wire RST_B,
  input wire [2:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [15:0] RDATA,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire SCL_IN,
  input wire SCL_OUT,
  input wire SCL_OE,
  input wire DATA_SERVICE_LINE,
  input wire PROTOCOL_SERVICE_LINE,
  input wire END_SERVICE_LINE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////
  // Shadow of the control word, so buffer rounds and master activity can be recognised
  reg [15:0] ctl_reg;
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) ctl_reg <= 16'h0000;
    else if (WR && ADDR == 3'h1) ctl_reg <= WDATA;
  end
  wire any_line = DATA_SERVICE_LINE | PROTOCOL_SERVICE_LINE | END_SERVICE_LINE;
  sequence s_round; WR && ADDR == 3'h4 && !ctl_reg[11] && ctl_reg[7] && !ctl_reg[6]; endsequence
  sequence s_flag_low; 1'b1 ##1 !DATA_SERVICE_LINE; endsequence
  property p_sda_low; SDA_OE |-> SDA_OUT == 1'b0; endproperty
  property p_scl_low; SCL_OE |-> SCL_OUT == 1'b0; endproperty
  property p_hold; any_line && SCL_OE && ctl_reg[4] && !WR |=> SCL_OE || !any_line; endproperty
  property p_rd_idle; !RD |=> RDATA == 16'h0000; endproperty
  property p_unmapped; RD && ADDR > 3'h5 |=> RDATA == 16'h0000; endproperty
  property p_round; s_round |=> s_flag_low; endproperty
  property p_data_set; WR && ADDR == 3'h2 && WDATA[5] |=> ##1 DATA_SERVICE_LINE; endproperty
  property p_prot_set; WR && ADDR == 3'h2 && WDATA[6] |=> ##1 PROTOCOL_SERVICE_LINE; endproperty
  property p_end_set; WR && ADDR == 3'h2 && WDATA[7] |=> ##1 END_SERVICE_LINE; endproperty
  property p_init; WR && ADDR == 3'h1 && WDATA[3:2] == 2'h0 |=> ##[1:4] !SCL_OE && !SDA_OE; endproperty
  a_sda_low: assert property (p_sda_low) else $error("data line driven high");
  a_scl_low: assert property (p_scl_low) else $error("clock line driven high");
  a_hold: assert property (p_hold) else $error("clock released with request pending");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_unmapped: assert property (p_unmapped) else $error("unmapped index read nonzero");
  a_round: assert property (p_round) else $error("data request kept after full round");
  a_data_set: assert property (p_data_set) else $error("data line missed set");
  a_prot_set: assert property (p_prot_set) else $error("protocol line missed set");
  a_end_set: assert property (p_end_set) else $error("end line missed set");
  a_init: assert property (p_init) else $error("lines held after init");
endmodule // i2c_bus_controller_sva
bind i2c_bus_controller i2c_bus_controller_sva chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .DATA_SERVICE_LINE(DATA_SERVICE_LINE),
  .PROTOCOL_SERVICE_LINE(PROTOCOL_SERVICE_LINE), .END_SERVICE_LINE(END_SERVICE_LINE));

// ### dv/i2c_bus_controller_tb.sv
// Self-checking testbench for the two-wire bus controller
`timescale 1ns/100ps
module i2c_bus_controller_tb;
  reg ref_clk = 1'b0;
  reg rst_b = 1'b0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [2:0] addr = 3'h0;
  reg [15:0] wdata = 16'h0000;
  wire [15:0] rdata;
  wire sda_out, sda_oe, scl_out, scl_oe, dsl, psl, esl, pull;
  wire [7:0] got;
  wire [15:0] period;
  integer error_cnt = 0;
  integer n_tests = 0;
  // Wired-AND with pull-ups: a released line reads high
  wire scl = ~scl_oe;
  wire sda = ~(sda_oe | pull);
  i2c_bus_controller dut (.REF_CLK(ref_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SCL_IN(scl), .SCL_OUT(scl_out),
    .SCL_OE(scl_oe), .DATA_SERVICE_LINE(dsl), .PROTOCOL_SERVICE_LINE(psl), .END_SERVICE_LINE(esl));
  i2c_far_node far (.clk(ref_clk), .rst_b(rst_b), .scl(scl), .sda(sda), .pull(pull), .got(got), .period(period));
  initial forever #25 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task chk(input [15:0] g, input [15:0] e); begin
    n_tests = n_tests + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  end endtask
  task wreg(input [2:0] a, input [15:0] d); begin
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  end endtask
  // Read data stand only in the cycle after the strobe
  task rchk(input [2:0] a, input [15:0] m, input [15:0] e); begin
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  end endtask
  task final_report; begin
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  end endtask
  ////////////////////////////////////////
  task t_reset; begin
    rchk(3'h4, 16'hffff, 16'h0000);
    rchk(3'h5, 16'hffff, 16'h0000);
    rchk(3'h6, 16'hffff, 16'h0000);
    $display("test reset done");
  end endtask
  task t_addr; begin
    wreg(3'h1, 16'h0001);
    wreg(3'h3, 16'h03ff);
    rchk(3'h3, 16'h03ff, 16'h03ff);
    wreg(3'h1, 16'h0000);
    wreg(3'h3, 16'h01ff);
    rchk(3'h3, 16'h01ff, 16'h01fe);
    $display("test address done");
  end endtask
  task t_buf; begin
    wreg(3'h1, 16'h0480);
    wreg(3'h2, 16'h00e0);
    @(posedge ref_clk);
    #1 chk({13'h0000, dsl, psl, esl}, 16'h0007);
    wreg(3'h4, 16'h1234);
    rchk(3'h2, 16'h07e0, 16'h07c0);
    wreg(3'h1, 16'h0c80);
    wreg(3'h2, 16'h0020);
    wreg(3'h4, 16'h5678);
    rchk(3'h2, 16'h0020, 16'h0020);
    wreg(3'h5, 16'h9abc);
    rchk(3'h2, 16'h0720, 16'h0700);
    rchk(3'h5, 16'hffff, 16'h9abc);
    wreg(3'h1, 16'h0cc0);
    wreg(3'h2, 16'h0020);
    wreg(3'h4, 16'h1111);
    wreg(3'h5, 16'h2222);
    rchk(3'h2, 16'h0020, 16'h0020);
    wreg(3'h2, 16'h0000);
    $display("test buffer done");
  end endtask
  // One master byte; the far node measures the first bit period in system clocks
  task t_xfer(input [15:0] adr, input [7:0] pre, input [15:0] exp); integer i; begin
    wreg(3'h1, 16'h0000);
    wreg(3'h2, 16'h0000);
    wreg(3'h3, adr);
    wreg(3'h0, {pre, 8'h11});
    wreg(3'h1, 16'h0088);
    wreg(3'h4, 16'h00a5);
    wreg(3'h1, 16'h0098);
    i = 0;
    while (dsl !== 1'b1 && i < 5000) begin
      @(posedge ref_clk);
      #1 i = i + 1;
    end
    chk({15'h0000, dsl}, 16'h0001);
    chk({8'h00, got}, 16'h00a5);
    chk(period, exp);
    rchk(3'h2, 16'h0008, 16'h0000);
    wreg(3'h1, 16'h0088);
    wreg(3'h2, 16'h0000);
    i = 0;
    while ((scl_oe | sda_oe) !== 1'b0 && i < 2000) begin
      @(posedge ref_clk);
      #1 i = i + 1;
    end
    chk({14'h0000, scl_oe, sda_oe}, 16'h0000);
    @(posedge ref_clk);
    #1 chk({15'h0000, esl}, 16'h0001);
    $display("test transfer done");
  end endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_reset;
    t_addr;
    t_buf;
    t_xfer(16'h0000, 8'h01, 16'h0008);
    t_xfer(16'h2000, 8'h00, 16'h0020);
    t_xfer(16'h4000, 8'h00, 16'h0100);
    t_xfer(16'h8000, 8'h80, 16'h0008);
    final_report;
  end
  // Watchdog: the whole sequence needs well under this many cycles
  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt = error_cnt + 1;
    final_report;
  end
endmodule // i2c_bus_controller_tb
